// ===== sfpi_pkg.sv
/*
 * Shared constants and types for the serial flash pin interface.
 * Assumes one system clock at 50 MHz that oversamples the serial clock pin.
 */
package sfpi_pkg;

    // ==========================================================
    // Sizes
    localparam int SFPI_BUF_DEPTH = 256;
    localparam int SFPI_BUF_AW = 8;
    localparam int SFPI_SYNC_W = 6;
    localparam logic [3:0] SFPI_BYTE_BITS = 4'h8;
    localparam logic [2:0] SFPI_LAST_BIT = 3'h7;

    // ==========================================================
    // Bits moved per falling edge in each transfer mode
    localparam logic [3:0] SFPI_STEP_SINGLE = 4'h1;
    localparam logic [3:0] SFPI_STEP_DUAL = 4'h2;
    localparam logic [3:0] SFPI_STEP_QUAD = 4'h4;

    // ==========================================================
    // Status-lock pattern that makes the protect pin live
    localparam logic SFPI_LOCK_UPPER_WP = 1'b0;
    localparam logic SFPI_LOCK_LOWER_WP = 1'b1;

    typedef enum logic [1:0] {
        SFPI_XM_SINGLE = 2'h0,
        SFPI_XM_DUAL = 2'h1,
        SFPI_XM_QUAD = 2'h2
    } sfpi_xfer_mode_t;

    typedef enum logic [3:0] {
        SFPI_ST_STANDBY = 4'h1,
        SFPI_ST_SELECT = 4'h2,
        SFPI_ST_PAUSE = 4'h4,
        SFPI_ST_SELFTIME = 4'h8
    } sfpi_state_t;

    // Pin levels travel together through the synchroniser
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic [3:0] dl;
    } sfpi_pins_t;

endpackage : sfpi_pkg

// ===== sfpi_sync.sv
/*
 * Two-flop synchroniser for a bus of independent pin levels.
 * Assumes each bit is a level with no relation to its neighbours.
 */
`timescale 1ns/1ps
module sfpi_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Levels
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // ==========================================================
    // Idle level of every pin is high (pull-ups)
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            meta_ff <= '1;
            sync_ff <= '1;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;

endmodule : sfpi_sync

// ===== sfpi_top.sv
/*
 * Pin-level control of a serial flash: select framing, edge timing, multi-line
 * reads, protect and pause pins, and the 256-byte receive buffer.
 * Assumes the serial clock is at most a quarter of clock_i so that every
 * serial edge is seen after synchronisation; config bits come from logic.
 */
// Overview of operation
// - A falling select begins an operation; decoding starts only then.
// - A rising select ends the current operation.
// - Ending during a self-timed cycle stays active until the cycle completes.
// - Deselected means standby, not deep power-down, with output line floating.
// - Serial input is ignored while deselected.
// - Input bits are sampled on rising serial clock edges.
// - Output data changes only on falling serial clock edges.
// - Multi-line reads turn input line into data line 0, two or four bits.
// - Output line stays output as data line 1 in multi-line reads.
// - Protect pin is live only with quad off and lock bits 0 and 1.
// - Protect pin low in protection mode blocks status register changes.
// - With quad enabled the protect pin is data line 2 for quad.
// - A 256-byte buffer sits behind the interface, filled from single-line input only.
// - With quad off, hold/reset pin is pause or reset by a config bit.
// - Pause enters on hold falling, leaves on hold rising, both with clock low.
`timescale 1ns/1ps
module sfpi_top
    import sfpi_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Serial pins
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic [3:0] data_line_i,
    output logic [3:0] data_line_o,
    output logic [3:0] data_line_oe_o,
    // Configuration
    input wire logic quad_lines_enable_i,
    input wire logic status_lock_bit_upper_i,
    input wire logic status_lock_bit_lower_i,
    input wire logic hold_is_reset_i,
    input wire logic busy_i,
    // Transmit side
    input wire logic tx_en_i,
    input wire sfpi_xfer_mode_t tx_mode_i,
    input wire logic [7:0] tx_byte_i,
    output logic tx_take_o,
    // Receive side and buffer
    output logic frame_start_o,
    output logic frame_end_o,
    output logic [7:0] rx_byte_o,
    output logic rx_valid_o,
    input wire logic [SFPI_BUF_AW-1:0] buf_addr_i,
    output logic [7:0] buf_data_o,
    output logic [SFPI_BUF_AW-1:0] buf_count_o,
    // Status
    output logic standby_o,
    output logic paused_o,
    output logic hw_reset_o,
    output logic status_write_block_o
);
    sfpi_pins_t pins_s;
    sfpi_state_t state_ff, nxt_state;
    logic sck_q_ff, cs_q_ff, hold_q_ff;
    logic [7:0] rx_sh_ff;
    logic [2:0] rx_cnt_ff;
    logic [7:0] tx_sh_ff;
    logic [3:0] tx_cnt_ff;
    logic [3:0] dl_out_ff;
    logic [7:0] rx_byte_ff, buf_data_ff;
    logic rx_valid_ff, tx_take_ff, block_ff;
    logic [SFPI_BUF_AW-1:0] wr_ptr_ff;
    logic [7:0] buf_mem [0:SFPI_BUF_DEPTH-1];

    // ==========================================================
    // Pin synchronisation and edge detection
    sfpi_sync #(.WIDTH(SFPI_SYNC_W)) u_sync (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .async_i({cs_n_i, sck_i, data_line_i}),
        .sync_o(pins_s)
    );

    wire cs_fall = cs_q_ff & ~pins_s.cs_n;
    wire cs_rise = ~cs_q_ff & pins_s.cs_n;
    wire sck_rise = ~sck_q_ff & pins_s.sck;
    wire sck_fall = sck_q_ff & ~pins_s.sck;
    wire selected = ~pins_s.cs_n;
    wire shifting = (state_ff == SFPI_ST_SELECT) && selected;

    // ==========================================================
    // Pin roles
    wire wp_mode = ~quad_lines_enable_i && (status_lock_bit_upper_i == SFPI_LOCK_UPPER_WP)
        && (status_lock_bit_lower_i == SFPI_LOCK_LOWER_WP);
    wire hold_mode = ~quad_lines_enable_i & ~hold_is_reset_i;
    wire hold_pin = pins_s.dl[3];
    wire hold_enter = hold_mode & selected & ~pins_s.sck & hold_q_ff & ~hold_pin;
    wire hold_leave = hold_mode & selected & ~pins_s.sck & ~hold_q_ff & hold_pin;
    // Quad falls back to single when the upper lines are not data lines
    wire quad_ok = quad_lines_enable_i;
    wire [3:0] step = (tx_mode_i == SFPI_XM_DUAL) ? SFPI_STEP_DUAL :
        ((tx_mode_i == SFPI_XM_QUAD) && quad_ok) ? SFPI_STEP_QUAD : SFPI_STEP_SINGLE;
    wire [7:0] tx_src = (tx_cnt_ff == 4'h0) ? tx_byte_i : tx_sh_ff;
    wire [3:0] tx_nib = (step == SFPI_STEP_QUAD) ? tx_src[7:4] :
        (step == SFPI_STEP_DUAL) ? {2'h0, tx_src[7:6]} : {2'h0, tx_src[7], 1'b0};
    wire [3:0] tx_left = ((tx_cnt_ff == 4'h0) ? SFPI_BYTE_BITS : tx_cnt_ff) - step;
    wire driving = shifting & tx_en_i;

    // ==========================================================
    // Frame state
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            SFPI_ST_STANDBY: if (cs_fall) nxt_state = SFPI_ST_SELECT;
            SFPI_ST_SELECT: begin
                if (cs_rise) nxt_state = busy_i ? SFPI_ST_SELFTIME : SFPI_ST_STANDBY;
                else if (hold_enter) nxt_state = SFPI_ST_PAUSE;
            end
            SFPI_ST_PAUSE: begin
                if (cs_rise) nxt_state = busy_i ? SFPI_ST_SELFTIME : SFPI_ST_STANDBY;
                else if (hold_leave) nxt_state = SFPI_ST_SELECT;
            end
            SFPI_ST_SELFTIME: begin
                if (cs_fall) nxt_state = SFPI_ST_SELECT;
                else if (!busy_i) nxt_state = SFPI_ST_STANDBY;
            end
            default: nxt_state = SFPI_ST_STANDBY;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state_ff <= SFPI_ST_STANDBY;
            sck_q_ff <= 1'b1;
            cs_q_ff <= 1'b1;
            hold_q_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            sck_q_ff <= pins_s.sck;
            cs_q_ff <= pins_s.cs_n;
            hold_q_ff <= hold_pin;
        end
    end

    // ==========================================================
    // Receive: rising edges, first bit is the most significant
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || cs_fall) begin
            rx_sh_ff <= 8'h00;
            rx_cnt_ff <= 3'h0;
            rx_valid_ff <= 1'b0;
        end else begin
            rx_valid_ff <= 1'b0;
            if (shifting && sck_rise) begin
                rx_sh_ff <= {rx_sh_ff[6:0], pins_s.dl[0]};
                rx_cnt_ff <= rx_cnt_ff + 3'h1;
                rx_valid_ff <= (rx_cnt_ff == SFPI_LAST_BIT);
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rx_byte_ff <= 8'h00;
        end else if (shifting && sck_rise && rx_cnt_ff == SFPI_LAST_BIT) begin
            rx_byte_ff <= {rx_sh_ff[6:0], pins_s.dl[0]};
        end
    end

    // ==========================================================
    // Byte buffer: filled from the line, read by the array side
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || cs_fall) begin
            wr_ptr_ff <= 8'h00;
        end else if (rx_valid_ff) begin
            wr_ptr_ff <= wr_ptr_ff + 8'h01;
        end
    end

    // Pointer wraps so a long write overwrites from the start of the page
    always_ff @(posedge clock_i) begin
        if (rx_valid_ff) begin
            buf_mem[wr_ptr_ff] <= rx_byte_ff;
        end
        buf_data_ff <= buf_mem[buf_addr_i];
    end

    // ==========================================================
    // Transmit: falling edges only, 1, 2 or 4 bits each
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || cs_fall) begin
            tx_sh_ff <= 8'h00;
            tx_cnt_ff <= 4'h0;
            dl_out_ff <= 4'h0;
            tx_take_ff <= 1'b0;
        end else begin
            tx_take_ff <= 1'b0;
            if (driving && sck_fall) begin
                dl_out_ff <= tx_nib;
                tx_sh_ff <= tx_src << step;
                tx_cnt_ff <= tx_left;
                tx_take_ff <= (tx_cnt_ff == 4'h0);
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            block_ff <= 1'b0;
        end else begin
            block_ff <= wp_mode & ~pins_s.dl[2];
        end
    end

    // ==========================================================
    // Outputs
    assign data_line_o = dl_out_ff;
    assign data_line_oe_o[1] = driving;
    assign data_line_oe_o[0] = driving && (step != SFPI_STEP_SINGLE);
    assign data_line_oe_o[2] = driving && (step == SFPI_STEP_QUAD);
    assign data_line_oe_o[3] = driving && (step == SFPI_STEP_QUAD);
    assign tx_take_o = tx_take_ff;
    assign frame_start_o = cs_fall;
    assign frame_end_o = cs_rise;
    assign rx_byte_o = rx_byte_ff;
    assign rx_valid_o = rx_valid_ff;
    assign buf_data_o = buf_data_ff;
    assign buf_count_o = wr_ptr_ff;
    assign standby_o = (state_ff == SFPI_ST_STANDBY);
    assign paused_o = (state_ff == SFPI_ST_PAUSE);
    assign hw_reset_o = ~quad_lines_enable_i & hold_is_reset_i & ~hold_pin;
    assign status_write_block_o = block_ff;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    a_start_on_fall: assert property ($rose(state_ff == SFPI_ST_SELECT) |->
        $past(cs_fall) || $past(hold_leave)) else $error("select without cs fall");
    a_end_on_rise: assert property (cs_rise && state_ff == SFPI_ST_SELECT |=>
        state_ff != SFPI_ST_SELECT) else $error("operation not ended");
    a_busy_no_standby: assert property (state_ff == SFPI_ST_SELFTIME && busy_i && !cs_fall
        |=> state_ff == SFPI_ST_SELFTIME) else $error("standby during cycle");
    a_float_deselect: assert property (pins_s.cs_n |-> data_line_oe_o == 4'h0)
        else $error("driving while deselected");
    a_ignore_input: assert property (!shifting |=> $stable(rx_cnt_ff) || $past(cs_fall))
        else $error("bit taken while deselected");
    a_rx_byte_msb: assert property (shifting && sck_rise && rx_cnt_ff == SFPI_LAST_BIT |=>
        rx_valid_o && rx_byte_o[0] == $past(pins_s.dl[0])) else $error("rx byte bad");
    a_out_on_fall: assert property (!$stable(data_line_o) && !$past(cs_fall) |->
        $past(sck_fall)) else $error("output moved off falling edge");
    a_quad_lines: assert property (data_line_oe_o[2] |-> quad_lines_enable_i &&
        data_line_oe_o[0] && data_line_oe_o[1]) else $error("quad without enable");
    a_wp_block: assert property (wp_mode && !pins_s.dl[2] |=> status_write_block_o)
        else $error("protect not applied");
    a_pause_exit: assert property (state_ff == SFPI_ST_PAUSE && hold_leave && !cs_rise |=>
        state_ff == SFPI_ST_SELECT) else $error("pause not left");

    c_byte_rx: cover property (rx_valid_o);
    c_quad_out: cover property (tx_take_o && data_line_oe_o[3]);
    c_pause: cover property (state_ff == SFPI_ST_PAUSE);
    c_selftime: cover property (state_ff == SFPI_ST_SELFTIME ##1 standby_o);

endmodule : sfpi_top

// ===== sfpi_host.sv
/* Host model that frames, clocks and samples the flash pins.
   Assumes the bench merges pin levels using the design's output enables. */
`timescale 1ns/1ps
module sfpi_host (
    // Clock
    input wire logic clock_i,
    // Pins
    input wire logic [3:0] pins_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic mosi_o,
    output logic [31:0] cap_o
);
    // Four clocks a phase keeps each sck level above the sampling minimum
    localparam int HALF = 4;
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        mosi_o = 1'b0;
        cap_o = 32'h0;
    end
    // ==========================================================
    // Framing
    task automatic select(input logic mode3);
        sck_o = mode3;
        repeat (HALF) @(negedge clock_i);
        cs_n_o = 1'b0;
        repeat (HALF) @(negedge clock_i);
    endtask : select
    task automatic deselect(input logic mode3);
        if (!mode3) sck_o = 1'b0;
        repeat (HALF) @(negedge clock_i);
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        repeat (HALF) @(negedge clock_i);
    endtask : deselect
    // ==========================================================
    // Bits go out before each rise; all pins are captured at the rise
    task automatic shift(input logic [15:0] dat, input int nbits);
        for (int i = 0; i < nbits; i++) begin
            sck_o = 1'b0;
            mosi_o = dat[15-i];
            repeat (HALF) @(negedge clock_i);
            sck_o = 1'b1;
            cap_o = {cap_o[27:0], pins_i};
            repeat (HALF) @(negedge clock_i);
        end
    endtask : shift
endmodule : sfpi_host

// ===== tb_sfpi_top.sv
/* Self-checking bench for the serial flash pin interface.
   Assumes pin changes settle in the design within six clocks. */
`timescale 1ns/1ps
module tb_sfpi_top;
    import sfpi_pkg::*;
    typedef struct packed {
        logic [15:0] dat;
        logic [1:0] nbytes;
        logic mode3;
    } sfpi_row_t;
    sfpi_row_t rows [4] = '{'{16'hA53C, 2'h1, 1'h0}, '{16'h5AC3, 2'h1, 1'h1},
                            '{16'h0180, 2'h2, 1'h0}, '{16'hFF00, 2'h2, 1'h1}};
    sfpi_xfer_mode_t rd_mode [4] = '{SFPI_XM_SINGLE, SFPI_XM_DUAL, SFPI_XM_QUAD, SFPI_XM_QUAD};
    logic [3:0] rd_oe [4] = '{4'h2, 4'h3, 4'hF, 4'h2};
    int rd_bits [4] = '{8, 4, 2, 8};
    logic [7:0] rd_byte [4] = '{8'hC6, 8'h39, 8'hA5, 8'h5A};
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic cs_n, sck, mosi, tx_take, fs, fe, rx_valid, standby, paused, hwr, blk;
    logic wp_lvl, hold_lvl, qe, up, lo, hr;
    logic busy, tx_en;
    sfpi_xfer_mode_t tx_mode;
    logic [7:0] tx_byte, buf_addr, rx_byte, buf_data, buf_count, got;
    logic [3:0] dl_o, dl_oe, pins;
    logic [31:0] cap;
    int err_total = 0, checks = 0, fs_cnt = 0, fe_cnt = 0, rx_cnt = 0, nsel = 0, n0;
    int tk_cnt = 0;
    always #10 clock_i = ~clock_i;
    // Undriven line 1 shows the inverse of its last value, lines 2 and 3 are pulled
    assign pins = {dl_oe[3] ? dl_o[3] : hold_lvl, dl_oe[2] ? dl_o[2] : wp_lvl,
                   dl_oe[1] ? dl_o[1] : ~dl_o[1], dl_oe[0] ? dl_o[0] : mosi};
    sfpi_host host (.clock_i(clock_i), .pins_i(pins), .cs_n_o(cs_n), .sck_o(sck),
                    .mosi_o(mosi), .cap_o(cap));
    sfpi_top uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n), .sck_i(sck),
        .data_line_i(pins), .data_line_o(dl_o), .data_line_oe_o(dl_oe),
        .quad_lines_enable_i(qe), .status_lock_bit_upper_i(up), .status_lock_bit_lower_i(lo),
        .hold_is_reset_i(hr), .busy_i(busy), .tx_en_i(tx_en), .tx_mode_i(tx_mode),
        .tx_byte_i(tx_byte), .tx_take_o(tx_take), .frame_start_o(fs), .frame_end_o(fe),
        .rx_byte_o(rx_byte), .rx_valid_o(rx_valid), .buf_addr_i(buf_addr),
        .buf_data_o(buf_data), .buf_count_o(buf_count), .standby_o(standby),
        .paused_o(paused), .hw_reset_o(hwr), .status_write_block_o(blk));
    always @(posedge clock_i) begin
        if (fs === 1'b1) fs_cnt++;
        if (fe === 1'b1) fe_cnt++;
        if (rx_valid === 1'b1) rx_cnt++;
        if (tx_take === 1'b1) tk_cnt++;
    end
    // ==========================================================
    // Checking and closing
    task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : cmp_byte
    task automatic cmp_bit(input string what, input logic exp, input logic seen);
        cmp_byte(what, {7'h00, exp}, {7'h00, seen});
    endtask : cmp_bit
    task automatic wrap_up;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    task automatic clk(input int n);
        repeat (n) @(negedge clock_i);
    endtask : clk
    // Oldest capture sits highest; line 1 carries single, lines 1:0 dual, 3:0 quad
    function automatic logic [7:0] unpack(input logic [31:0] c, input int bits);
        logic [7:0] r;
        for (int k = 0; k < 8; k++) r[k] = c[4*k+1];
        if (bits == 4) r = {c[13:12], c[9:8], c[5:4], c[1:0]};
        if (bits == 2) r = c[7:0];
        return r;
    endfunction : unpack
    initial begin
        repeat (30000) @(posedge clock_i);
        err_total++;
        wrap_up();
    end
    // ==========================================================
    // Main sequence
    initial begin
        // Pulled-up protect and hold lines, everything else quiet
        {wp_lvl, hold_lvl, qe, up, lo, hr, busy, tx_en} = 8'hC0;
        tx_mode = SFPI_XM_SINGLE;
        tx_byte = 8'h00;
        buf_addr = 8'h00;
        clk(5);
        sys_rst_i = 1'b0;
        clk(2);
        cmp_bit("standby after reset", 1'b1, standby);
        cmp_byte("oe after reset", 8'h00, {4'h0, dl_oe});
        foreach (rows[r]) begin
            n0 = rx_cnt;
            host.select(rows[r].mode3);
            nsel++;
            cmp_bit("standby selected", 1'b0, standby);
            host.shift(rows[r].dat, 8 * rows[r].nbytes);
            host.deselect(rows[r].mode3);
            cmp_byte("rx pulses", {6'h00, rows[r].nbytes}, 8'(rx_cnt - n0));
            got = (rows[r].nbytes == 2'h1) ? rows[r].dat[15:8] : rows[r].dat[7:0];
            cmp_byte("rx byte", got, rx_byte);
            cmp_byte("buf count", {6'h00, rows[r].nbytes}, buf_count);
            cmp_bit("standby deselected", 1'b1, standby);
            for (int i = 0; i < rows[r].nbytes; i++) begin
                buf_addr = 8'(i);
                clk(2);
                got = (i == 0) ? rows[r].dat[15:8] : rows[r].dat[7:0];
                cmp_byte("buf data", got, buf_data);
            end
        end
        // Clocks while deselected and a partial byte both give nothing
        n0 = rx_cnt;
        host.shift(16'hFFFF, 16);
        host.select(1'b0);
        nsel++;
        host.shift(16'hA000, 4);
        host.deselect(1'b0);
        clk(4);
        cmp_byte("rx pulses ignored", 8'h00, 8'(rx_cnt - n0));
        tx_en = 1'b1;
        for (int m = 0; m < 4; m++) begin
            qe = (m == 2);
            tx_mode = rd_mode[m];
            tx_byte = rd_byte[m];
            n0 = tk_cnt;
            host.select(1'b1);
            nsel++;
            host.shift(16'h0000, rd_bits[m]);
            cmp_byte("read oe", {4'h0, rd_oe[m]}, {4'h0, dl_oe});
            host.deselect(1'b1);
            cmp_byte("oe released", 8'h00, {4'h0, dl_oe});
            cmp_byte("read byte", rd_byte[m], unpack(cap, rd_bits[m]));
            cmp_byte("tx takes", 8'h01, 8'(tk_cnt - n0));
        end
        tx_en = 1'b0;
        qe = 1'b0;
        busy = 1'b1;
        host.select(1'b0);
        nsel++;
        host.deselect(1'b0);
        clk(8);
        cmp_bit("standby held by busy", 1'b0, standby);
        busy = 1'b0;
        clk(4);
        cmp_bit("standby after busy", 1'b1, standby);
        host.select(1'b0);
        nsel++;
        hold_lvl = 1'b0;
        clk(6);
        cmp_bit("paused on hold", 1'b1, paused);
        hold_lvl = 1'b1;
        clk(6);
        cmp_bit("pause left", 1'b0, paused);
        host.shift(16'h3C00, 8);
        host.deselect(1'b0);
        cmp_byte("rx after pause", 8'h3C, rx_byte);
        for (int c = 0; c < 64; c++) begin
            {qe, up, lo, wp_lvl, hr, hold_lvl} = 6'(c);
            clk(6);
            cmp_bit("write block", ~qe & ~up & lo & ~wp_lvl, blk);
            cmp_bit("hw reset", ~qe & hr & ~hold_lvl, hwr);
        end
        cmp_byte("frame starts", 8'(nsel), 8'(fs_cnt));
        cmp_byte("frame ends", 8'(nsel), 8'(fe_cnt));
        wrap_up();
    end
endmodule : tb_sfpi_top
